// ### hdl/svi_map.svh
// Constants of the scroll pointer and reduced colour command block.
// Assumes the host writes 8-bit command and parameter bytes on the low data lanes.
`ifndef SVI_MAP_SVH
`define SVI_MAP_SVH
`define SVI_SCROLL_START_CMD 8'h37
`define SVI_REDUCED_COLOUR_EXIT_CMD 8'h38
`define SVI_REDUCED_COLOUR_ENTRY_CMD 8'h39
`define SVI_POINTER_RESET 16'h0000
`define SVI_REDUCED_RESET 1'b0
`define SVI_MAC_VERTICAL_REFRESH_ORDER 4
`endif

// ### hdl/svi_pkg.sv
// Types shared by the scroll pointer and reduced colour command block.
// Assumes the scroll geometry is held by the scroll definition decoder elsewhere.
package svi_pkg;
   // Sizes set by the scroll definition command
   typedef struct packed
   {
      logic [15:0] top_fixed;
      logic [15:0] scroll_area;
      logic [15:0] bottom_fixed;
   } svi_geom_t;

   // Host bus write, already synchronous to the clock
   typedef struct packed
   {
      logic data_command_select;
      logic write_strobe_n;
      logic read_strobe_n;
      logic [7:0] data;
   } svi_bus_t;

   typedef enum logic [1:0]
   {
      SVI_ST_CMD,
      SVI_ST_UPPER,
      SVI_ST_LOWER
   } svi_state_t;
endpackage : svi_pkg

// ### hdl/svi_top.sv
// Scroll start pointer and reduced colour mode command handling.
// Assumes bus pins are synchronous to i_clk and the panel timing pulses i_frame_start.
`timescale 1ns/10ps
`include "svi_map.svh"

module svi_top #(
   parameter int COMP_W = 6
) (
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_sw_reset,
   input wire svi_pkg::svi_bus_t i_bus,
   input wire svi_pkg::svi_geom_t i_geom,
   input wire logic [7:0] i_memory_access_control,
   input wire logic i_frame_start,
   input wire logic i_line_valid,
   input wire logic [15:0] i_panel_line,
   input wire logic i_pix_valid,
   input wire logic [3*COMP_W-1:0] i_mem_pixel,
   output logic [15:0] o_scroll_line_pointer,
   output logic o_reduced_colour,
   output logic o_reduced_active,
   output logic o_line_valid,
   output logic [15:0] o_mem_line,
   output logic o_pix_valid,
   output logic [3*COMP_W-1:0] o_panel_pixel
);
   import svi_pkg::*;

   if (COMP_W < 2)
   begin : g_bad_comp_w
      $error("COMP_W must be at least 2");
   end

   // Panel line to frame memory line
   function automatic logic [15:0] svi_map_line(input logic [15:0] p, input svi_geom_t g,
                                                input logic [15:0] scroll_line_pointer, input logic ml);
      logic [17:0] total;
      logic [17:0] l;
      logic [17:0] s;
      logic [17:0] top_end;
      total = 18'(g.top_fixed) + 18'(g.scroll_area) + 18'(g.bottom_fixed);
      l = ml ? (total - 18'd1 - 18'(p)) : 18'(p);
      top_end = 18'(g.top_fixed) + 18'(g.scroll_area);
      s = l;
      if (l >= 18'(g.top_fixed) && l < top_end)
      begin
         s = (l - 18'(g.top_fixed)) + (18'(scroll_line_pointer) - 18'(g.top_fixed));
         if (s >= 18'(g.scroll_area))
         begin
            s = s - 18'(g.scroll_area);
         end
         s = s + 18'(g.top_fixed);
      end
      return s[15:0];
   endfunction : svi_map_line

   // Each component shown fully on or off from its top bit
   function automatic logic [3*COMP_W-1:0] svi_reduce(input logic [3*COMP_W-1:0] px);
      logic [3*COMP_W-1:0] r;
      r = '0;
      for (int c = 0; c < 3; c++)
      begin
         r[c*COMP_W +: COMP_W] = {COMP_W{px[c*COMP_W + COMP_W - 1]}};
      end
      return r;
   endfunction : svi_reduce

   svi_state_t state;
   logic strobe_prev;
   logic wr_edge;
   logic wr_cmd;
   logic wr_data;
   logic [7:0] upper_byte;
   logic [15:0] pending_ptr;
   logic [15:0] active_ptr;
   logic reduced_cmd;
   logic reduced_act;
   svi_geom_t act_geom;
   logic act_ml;
   logic any_reset;

   assign any_reset = i_srst | i_sw_reset;
   assign wr_edge = i_bus.write_strobe_n & ~strobe_prev;
   assign wr_cmd = wr_edge & ~i_bus.data_command_select;
   assign wr_data = wr_edge & i_bus.data_command_select;

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         strobe_prev <= 1'b1;
      end
      else
      begin
         strobe_prev <= i_bus.write_strobe_n;
      end
   end

   // Command and parameter sequencing
   always_ff @(posedge i_clk)
   begin
      if (any_reset)
      begin
         state <= SVI_ST_CMD;
      end
      else if (wr_cmd)
      begin
         state <= (i_bus.data == `SVI_SCROLL_START_CMD) ? SVI_ST_UPPER : SVI_ST_CMD;
      end
      else if (wr_data)
      begin
         unique case (state)
            SVI_ST_CMD: state <= SVI_ST_CMD;
            SVI_ST_UPPER: state <= SVI_ST_LOWER;
            SVI_ST_LOWER: state <= SVI_ST_CMD;
         endcase
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (any_reset)
      begin
         upper_byte <= 8'h00;
         pending_ptr <= `SVI_POINTER_RESET;
      end
      else if (wr_data && state == SVI_ST_UPPER)
      begin
         upper_byte <= i_bus.data;
      end
      else if (wr_data && state == SVI_ST_LOWER)
      begin
         pending_ptr <= {upper_byte, i_bus.data};
      end
   end

   // Reduced colour mode as commanded
   always_ff @(posedge i_clk)
   begin
      if (any_reset)
      begin
         reduced_cmd <= `SVI_REDUCED_RESET;
      end
      else if (wr_cmd && i_bus.data == `SVI_REDUCED_COLOUR_ENTRY_CMD)
      begin
         reduced_cmd <= 1'b1;
      end
      else if (wr_cmd && i_bus.data == `SVI_REDUCED_COLOUR_EXIT_CMD && reduced_cmd)
      begin
         reduced_cmd <= 1'b0;
      end
   end

   // Settings used by the scan, swapped only at a scan start or a reset to avoid tearing
   always_ff @(posedge i_clk)
   begin
      if (any_reset)
      begin
         active_ptr <= `SVI_POINTER_RESET;
         reduced_act <= `SVI_REDUCED_RESET;
         act_geom <= '0;
         act_ml <= 1'b0;
      end
      else if (i_frame_start)
      begin
         active_ptr <= pending_ptr;
         reduced_act <= reduced_cmd;
         act_geom <= i_geom;
         act_ml <= i_memory_access_control[`SVI_MAC_VERTICAL_REFRESH_ORDER];
      end
   end

   // Line address path
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_line_valid <= 1'b0;
         o_mem_line <= 16'h0000;
      end
      else
      begin
         o_line_valid <= i_line_valid;
         if (i_line_valid)
         begin
            o_mem_line <= svi_map_line(i_panel_line, act_geom, active_ptr, act_ml);
         end
      end
   end

   // Pixel colour path
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         o_pix_valid <= 1'b0;
         o_panel_pixel <= '0;
      end
      else
      begin
         o_pix_valid <= i_pix_valid;
         if (i_pix_valid)
         begin
            o_panel_pixel <= reduced_act ? svi_reduce(i_mem_pixel) : i_mem_pixel;
         end
      end
   end

   assign o_scroll_line_pointer = active_ptr;
   assign o_reduced_colour = reduced_cmd;
   assign o_reduced_active = reduced_act;

   logic [17:0] chk_total;
   assign chk_total = 18'(act_geom.top_fixed) + 18'(act_geom.scroll_area)
                    + 18'(act_geom.bottom_fixed);

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   property p_ptr_assemble;
      wr_data && state == SVI_ST_LOWER && !i_sw_reset
         |=> pending_ptr == {$past(upper_byte), $past(i_bus.data)};
   endproperty
   a_ptr_assemble: assert property (p_ptr_assemble) else $error("pointer bytes misassembled");

   property p_ptr_hold;
      !i_frame_start && !i_sw_reset |=> $stable(active_ptr);
   endproperty
   a_ptr_hold: assert property (p_ptr_hold) else $error("pointer changed mid scan");

   property p_ptr_apply;
      i_frame_start && !i_sw_reset |=> active_ptr == $past(pending_ptr);
   endproperty
   a_ptr_apply: assert property (p_ptr_apply) else $error("pointer not applied at scan");

   property p_first_scroll_line;
      i_line_valid && !act_ml && i_panel_line == act_geom.top_fixed
         && act_geom.scroll_area != 16'h0000 && !i_frame_start && !i_sw_reset
         |=> o_mem_line == $past(active_ptr);
   endproperty
   a_first_scroll_line: assert property (p_first_scroll_line) else $error("bad first line");

   property p_top_fixed;
      i_line_valid && !act_ml && i_panel_line < act_geom.top_fixed
         |=> o_mem_line == $past(i_panel_line);
   endproperty
   a_top_fixed: assert property (p_top_fixed) else $error("top fixed line moved");

   property p_reverse_order;
      i_line_valid && act_ml && 18'(i_panel_line) == chk_total - 18'd1
         && act_geom.top_fixed != 16'h0000 && !i_frame_start && !i_sw_reset
         |=> o_mem_line == 16'h0000;
   endproperty
   a_reverse_order: assert property (p_reverse_order) else $error("refresh order ignored");

   property p_sw_reset;
      i_sw_reset |=> active_ptr == 16'h0000 && pending_ptr == 16'h0000 && !reduced_cmd
         && !reduced_act;
   endproperty
   a_sw_reset: assert property (p_sw_reset) else $error("reset values wrong");

   property p_exit;
      wr_cmd && i_bus.data == `SVI_REDUCED_COLOUR_EXIT_CMD && !i_sw_reset
         |=> !reduced_cmd && $stable(pending_ptr);
   endproperty
   a_exit: assert property (p_exit) else $error("exit command misbehaved");

   property p_entry;
      wr_cmd && i_bus.data == `SVI_REDUCED_COLOUR_ENTRY_CMD && !i_sw_reset |=> reduced_cmd;
   endproperty
   a_entry: assert property (p_entry) else $error("entry command ignored");

   property p_reduce;
      i_pix_valid && reduced_act
         |=> o_panel_pixel[3*COMP_W-1 -: COMP_W] == {COMP_W{$past(i_mem_pixel[3*COMP_W-1])}}
            && o_panel_pixel[2*COMP_W-1 -: COMP_W] == {COMP_W{$past(i_mem_pixel[2*COMP_W-1])}}
            && o_panel_pixel[COMP_W-1 -: COMP_W] == {COMP_W{$past(i_mem_pixel[COMP_W-1])}};
   endproperty
   a_reduce: assert property (p_reduce) else $error("reduced colour wrong");

   property p_full;
      i_pix_valid && !reduced_act |=> o_panel_pixel == $past(i_mem_pixel);
   endproperty
   a_full: assert property (p_full) else $error("full colour altered");

   property p_line_valid;
      i_line_valid |=> o_line_valid;
   endproperty
   a_line_valid: assert property (p_line_valid) else $error("line request lost");

   property p_line_idle;
      !i_line_valid |=> !o_line_valid;
   endproperty
   a_line_idle: assert property (p_line_idle) else $error("spurious line output");

   property p_pix_valid;
      i_pix_valid |=> o_pix_valid;
   endproperty
   a_pix_valid: assert property (p_pix_valid) else $error("pixel lost");

   property p_stray_param;
      wr_data && state == SVI_ST_CMD && !i_sw_reset
         |=> $stable(pending_ptr) && state == SVI_ST_CMD;
   endproperty
   a_stray_param: assert property (p_stray_param) else $error("stray parameter taken");

   c_ptr_load: cover property (wr_data && state == SVI_ST_LOWER ##[1:50] i_frame_start);
   c_entry_apply: cover property (reduced_cmd && i_frame_start ##1 reduced_act);
   c_exit_apply: cover property (reduced_act && !reduced_cmd && i_frame_start);
   c_reverse: cover property (i_line_valid && act_ml);
   c_sw_reset: cover property (reduced_act && i_sw_reset ##1 !reduced_act);
endmodule : svi_top

// ### dv/svi_host.sv
// Host model that writes command and parameter bytes on the parallel bus.
// Assumes the device takes a write on the rising edge of the write strobe.
`timescale 1ns/10ps

module svi_host (
   input wire logic i_clk,
   output svi_pkg::svi_bus_t o_bus
);
   import svi_pkg::*;

   initial o_bus = '{1'b1, 1'b1, 1'b1, 8'h00};

   // Strobe low one cycle, high again, data held over the taking edge
   task automatic send(input logic sel, input logic [7:0] val);
      @(negedge i_clk);
      o_bus.data_command_select = sel;
      o_bus.data = val;
      o_bus.write_strobe_n = 1'b0;
      @(negedge i_clk);
      o_bus.write_strobe_n = 1'b1;
      @(negedge i_clk);
      // Released bus shows the inverse of the last byte
      o_bus.data = ~val;
      o_bus.data_command_select = ~sel;
   endtask : send
endmodule : svi_host

// ### dv/tb.sv
// Self-checking bench for the scroll pointer and reduced colour block.
// Assumes the host model drives the bus and the bench plays the panel timing.
`timescale 1ns/10ps

module tb;
   import svi_pkg::*;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_sw_reset = 1'b0;
   svi_bus_t i_bus;
   svi_geom_t i_geom = '0;
   logic [7:0] i_memory_access_control = 8'h00;
   logic i_frame_start = 1'b0;
   logic i_line_valid = 1'b0;
   logic [15:0] i_panel_line = 16'h0000;
   logic i_pix_valid = 1'b0;
   logic [17:0] i_mem_pixel = '0;
   logic [15:0] o_scroll_line_pointer, o_mem_line;
   logic o_reduced_colour, o_reduced_active, o_line_valid, o_pix_valid;
   logic [17:0] o_panel_pixel, px;
   int n_errors = 0;
   int n_compared = 0;
   int top, sc, bot, scroll_line_pointer, p, seed;

   always #10 i_clk = ~i_clk;

   svi_host i_svi_host (.i_clk(i_clk), .o_bus(i_bus));

   svi_top i_svi_top (.i_clk(i_clk), .i_srst(i_srst), .i_sw_reset(i_sw_reset), .i_bus(i_bus),
      .i_geom(i_geom), .i_memory_access_control(i_memory_access_control),
      .i_frame_start(i_frame_start), .i_line_valid(i_line_valid), .i_panel_line(i_panel_line),
      .i_pix_valid(i_pix_valid), .i_mem_pixel(i_mem_pixel),
      .o_scroll_line_pointer(o_scroll_line_pointer), .o_reduced_colour(o_reduced_colour),
      .o_reduced_active(o_reduced_active), .o_line_valid(o_line_valid), .o_mem_line(o_mem_line),
      .o_pix_valid(o_pix_valid), .o_panel_pixel(o_panel_pixel));

   task automatic check(input string name, input logic [17:0] exp, input logic [17:0] got);
      n_compared++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
         n_errors++;
      end
   endtask : check

   task automatic complete_run;
      $display("compared %0d mismatches %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : complete_run

   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask : tick

   task automatic frame;
      tick(2);
      i_frame_start = 1'b1;
      tick(1);
      i_frame_start = 1'b0;
      tick(1);
   endtask : frame

   task automatic scroll(input logic [15:0] v);
      i_svi_host.send(1'b0, 8'h37);
      i_svi_host.send(1'b1, v[15:8]);
      i_svi_host.send(1'b1, v[7:0]);
   endtask : scroll

   function automatic logic [15:0] map_line(input int pl, input logic ml);
      int l;
      l = ml ? top + sc + bot - 1 - pl : pl;
      if (l >= top && l < top + sc)
         l = top + ((l - top) + (scroll_line_pointer - top)) % sc;
      return 16'(l);
   endfunction : map_line

   function automatic logic [17:0] exp_pix(input logic [17:0] v, input logic red);
      return red ? {{6{v[17]}}, {6{v[11]}}, {6{v[5]}}} : v;
   endfunction : exp_pix

   task automatic pixels(input logic red);
      i_pix_valid = 1'b1;
      for (int j = 0; j < 10; j++)
      begin
         px = (j < 2) ? {18{j[0]}} ^ 18'h0_8208 : 18'($urandom());
         i_mem_pixel = px;
         tick(1);
         check("pix_valid", 1, o_pix_valid);
         check("panel_pixel", exp_pix(px, red), o_panel_pixel);
      end
      i_pix_valid = 1'b0;
   endtask : pixels

   initial
   begin
      #(20 * 2000);
      n_errors++;
      complete_run();
   end

   initial
   begin
      seed = $urandom(32'h0000_e233);
      tick(3);
      i_srst = 1'b0;
      check("pointer_reset", 0, o_scroll_line_pointer);
      check("reduced_reset", 0, o_reduced_colour);
      for (int k = 0; k < 8; k++)
      begin
         top = $urandom_range(0, 20);
         sc = $urandom_range(40, 100);
         bot = $urandom_range(0, 20);
         scroll_line_pointer = (k == 0) ? top : (k == 1) ? top + sc - 1 : top + $urandom_range(0, sc - 1);
         i_geom = '{16'(top), 16'(sc), 16'(bot)};
         i_memory_access_control = 8'($urandom());
         i_memory_access_control[4] = k[0];
         p = o_scroll_line_pointer;
         scroll(16'(scroll_line_pointer));
         check("pointer_held", 18'(p), o_scroll_line_pointer);
         frame();
         check("pointer_new", 18'(scroll_line_pointer), o_scroll_line_pointer);
         i_line_valid = 1'b1;
         for (int j = 0; j < 12; j++)
         begin
            p = (j == 0) ? top : (j == 1) ? top + sc + bot - 1 : $urandom_range(0, top + sc + bot - 1);
            i_panel_line = 16'(p);
            tick(1);
            check("line_valid", 1, o_line_valid);
            check("mem_line", map_line(p, k[0]), o_mem_line);
         end
         i_line_valid = 1'b0;
      end
      // Cut sequence: a command between the two bytes aborts the pointer write
      i_svi_host.send(1'b0, 8'h37);
      i_svi_host.send(1'b1, 8'h00);
      i_svi_host.send(1'b0, 8'h38);
      i_svi_host.send(1'b1, 8'h05);
      frame();
      check("pointer_abort", 18'(scroll_line_pointer), o_scroll_line_pointer);
      check("exit_unused", 0, o_reduced_colour);
      check("exit_active", 0, o_reduced_active);
      pixels(1'b0);
      i_svi_host.send(1'b0, 8'h39);
      tick(1);
      check("enter", 1, o_reduced_colour);
      check("enter_wait", 0, o_reduced_active);
      i_svi_host.send(1'b0, 8'h39);
      tick(1);
      check("enter_again", 1, o_reduced_colour);
      frame();
      check("enter_active", 1, o_reduced_active);
      pixels(1'b1);
      i_svi_host.send(1'b0, 8'h38);
      tick(1);
      check("exit", 0, o_reduced_colour);
      frame();
      check("exit_active", 0, o_reduced_active);
      pixels(1'b0);
      i_svi_host.send(1'b0, 8'h39);
      scroll(16'(top + 1));
      frame();
      check("sw_pointer_before", 18'(top + 1), o_scroll_line_pointer);
      check("sw_mode_before", 1, o_reduced_active);
      i_sw_reset = 1'b1;
      tick(1);
      i_sw_reset = 1'b0;
      check("sw_reduced", 0, o_reduced_colour);
      check("sw_active_now", 0, o_reduced_active);
      check("sw_pointer_now", 0, o_scroll_line_pointer);
      tick(1);
      frame();
      check("sw_pointer", 0, o_scroll_line_pointer);
      check("sw_active", 0, o_reduced_active);
      complete_run();
   end
endmodule : tb
